// ==== hdl/sctr_pkg.sv ====
// Constants shared by the sensor transceiver configuration and status bank.
package sctr_pkg;
   // ****************************************************************
   // Register addresses.
   // ****************************************************************
   localparam logic [5:0] A_GEN_CFG = 6'h01;   // Setup-phase configuration.
   localparam logic [5:0] A_CH_CTRL = 6'h02;   // Channel control.
   localparam logic [5:0] A_NOP = 6'h03;       // No operation.
   localparam logic [5:0] A_STATUS1 = 6'h04;   // First status register.
   localparam logic [5:0] A_BUF1_LO = 6'h08;   // Ch1 buffer, first word.
   localparam logic [5:0] A_BUF1_HI = 6'h0B;   // Ch1 buffer, last word.
   localparam logic [5:0] A_BUF2_LO = 6'h0C;   // Ch2 buffer, first word.
   localparam logic [5:0] A_BUF2_HI = 6'h0F;   // Ch2 buffer, last word.
   // ****************************************************************
   // Reset values and writable-bit masks (reserved bits read zero).
   // ****************************************************************
   localparam logic [15:0] GEN_CFG_RST = 16'h8000;
   localparam logic [15:0] CH_CTRL_RST = 16'h0442;
   localparam logic [15:0] GEN_CFG_WMASK = 16'hFFDF;
   localparam logic [15:0] CH_CTRL_WMASK = 16'h077B;
   // ****************************************************************
   // Configuration field positions; two-bit fields name their low bit.
   // ****************************************************************
   localparam int B_PAR = 15;
   localparam int B_AMUX_OFF = 14;
   localparam int B_CH2_BUF = 13;
   localparam int B_CH2_SRC = 11;
   localparam int B_CH2_METH = 10;
   localparam int B_CH1_BUF = 9;
   localparam int B_CH1_SRC = 7;
   localparam int B_CH1_METH = 6;
   localparam int B_CLK_SEL = 3;
   localparam int B_SIDG = 2;
   localparam int B_CHK_SRC = 1;
   localparam int B_REG_LVL = 0;
   // ****************************************************************
   // Channel control field positions; two-bit fields name their low bit.
   // ****************************************************************
   localparam int B_REG_EN = 10;
   localparam int B_CH2_REQ = 8;
   localparam int B_CH2_ALLOW = 6;
   localparam int B_CH2_ON = 5;
   localparam int B_CH1_REQ = 3;
   localparam int B_CH1_ALLOW = 1;
   localparam int B_CH1_ON = 0;
   // ****************************************************************
   // Status register: bits that show live conditions and are never latched.
   // ****************************************************************
   localparam logic [15:0] STATUS_LIVE_MASK = 16'h2A00;
   localparam int S_REG_DEEP_UV = 8;
   // ****************************************************************
   // Field encodings.
   // ****************************************************************
   localparam logic [1:0] SRC_PIN_A = 2'h0;
   localparam logic [1:0] SRC_HOST = 2'h1;
   localparam logic [1:0] SRC_AUTO = 2'h2;
   localparam logic [1:0] SRC_PIN_B = 2'h3;
   localparam logic [1:0] REQ_SHORT = 2'h1;
   localparam logic [1:0] REQ_LONG = 2'h2;
   localparam logic [1:0] CLK_EXT_1M = 2'h1;
   localparam logic [1:0] CLK_EXT_4M = 2'h2;
   localparam logic METHOD_TOOTH_GAP = 1'b0;
   localparam logic [4:0] PAYLOAD_SHORT = 5'h0A;
   localparam logic [4:0] PAYLOAD_LONG = 5'h10;
   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int CLK_MHZ = 50;
   localparam int PARITY_PERIOD_US = 150;
   localparam int PIN_TIMEOUT_US = 100;
   localparam int PARITY_CYCLES = PARITY_PERIOD_US * CLK_MHZ;
   localparam int PIN_TIMEOUT_CYCLES = PIN_TIMEOUT_US * CLK_MHZ;
endpackage : sctr_pkg

// ==== hdl/sctr_sync_chan.sv ====
// One channel's sync pulse request and pin timeout logic.
`timescale 1ns/1ns
`default_nettype none
module sctr_sync_chan #(
   parameter int TOUT_CYCLES = sctr_pkg::PIN_TIMEOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic chan_on,
   input wire logic buf_sel,
   input wire logic method_sel,
   input wire logic sync_allow,
   input wire logic [1:0] trig_src,
   input wire logic host_wr,
   input wire logic [1:0] host_code,
   input wire logic pin_level,
   output logic sync_pulse,
   output logic sync_long,
   output logic length_from_buffer,
   output logic method_eff,
   output logic tout_evt
);
   localparam int CW = $clog2(TOUT_CYCLES + 1);

   logic pin_q;      // Pin level one cycle ago, for edge detection.
   logic [CW-1:0] tout_cnt;   // Cycles the pin has stayed active.

   // ****************************************************************
   // Decoding.
   // ****************************************************************
   wire pin_src = (trig_src == sctr_pkg::SRC_PIN_A) || (trig_src == sctr_pkg::SRC_PIN_B); // RL6
   wire auto_src = (trig_src == sctr_pkg::SRC_AUTO);   // RL6
   wire from_buf = buf_sel | auto_src;                  // RL5
   wire code_ok = (host_code == sctr_pkg::REQ_SHORT) || (host_code == sctr_pkg::REQ_LONG); // RL12
   // The write strobe is the one-shot; a stored code never repeats.
   wire host_fire = host_wr & chan_on & (trig_src == sctr_pkg::SRC_HOST) & code_ok; // RL13
   wire pin_fire = pin_src & chan_on & pin_level & ~pin_q;
   wire fire = (host_fire | pin_fire) & sync_allow;     // RL15
   // With the buffer in use the code sets no length.
   wire next_long = host_fire & ~from_buf & (host_code == sctr_pkg::REQ_LONG); // RL14
   wire pin_held = pin_src & chan_on & pin_level;
   wire tout_hit = pin_held && (tout_cnt == CW'(TOUT_CYCLES - 1));

   // ****************************************************************
   // Registered outputs and pin timeout counter.
   // ****************************************************************
   // Saturating, so a stuck pin times out once.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_q <= 1'b0;
         tout_cnt <= '0;
         sync_pulse <= 1'b0;
         sync_long <= 1'b0;
         length_from_buffer <= 1'b0;
         method_eff <= sctr_pkg::METHOD_TOOTH_GAP;
         tout_evt <= 1'b0;
      end else if (ce) begin
         pin_q <= pin_level;
         sync_pulse <= fire;
         sync_long <= fire & next_long;
         length_from_buffer <= from_buf;
         // The method bit only counts while the buffer bit is set.
         method_eff <= buf_sel ? method_sel : sctr_pkg::METHOD_TOOTH_GAP; // RL7
         tout_evt <= tout_hit;   // RL19
         if (!pin_held) begin
            tout_cnt <= '0;
         end else if (tout_cnt != CW'(TOUT_CYCLES)) begin
            tout_cnt <= tout_cnt + 1'b1;
         end
      end
   end
endmodule : sctr_sync_chan
`default_nettype wire

// ==== hdl/sctr_regs.sv ====
// Configuration, channel control and first status registers of the transceiver.
// How it works
// RL1 - Write, read, read-write or read-clear kinds.
// RL2 - Setup writes allowed until programming ends.
// RL3 - Odd check bit rechecked every 150 us.
// RL4 - Bit 14 turns address multiplexing off.
// RL5 - Buffer bit or auto source: buffer length.
// RL6 - Source: pin, host command or automatic.
// RL7 - Method counts only with buffer bit.
// RL8 - Clock field: none, 1 MHz, 4 MHz.
// RL9 - Sensor ID only for 10/16-bit payloads.
// RL10 - Check bits from sensor or computed.
// RL11 - Regulator and channel enables, one is on.
// RL12 - Host sync code: none, short, long.
// RL13 - Host code acts once, not when off.
// RL14 - With buffer, short equals long.
// RL15 - Allow bit gates sync pulses.
// RL16 - No-op write changes nothing.
// RL17 - Flags clear on read, three live.
// RL18 - Deep undervoltage: regulator off, confirm clears.
// RL19 - Pin held over 100 us: timeout flag.
// RL20 - Buffer write while pending: fault.
// RL21 - Link errors, bad addresses: link fault.
// RL22 - Coupling test done, aborted, active bits.
// RL23 - Setup writes ignored after programming ends.
`timescale 1ns/1ns
`default_nettype none
module sctr_regs #(
   parameter int PAR_CYCLES = sctr_pkg::PARITY_CYCLES,
   parameter int TOUT_CYCLES = sctr_pkg::PIN_TIMEOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic ext_addr_claim,
   input wire logic end_of_programming_cmd,
   input wire logic link_frame_err,
   input wire logic sync1_pin,
   input wire logic sync2_pin,
   input wire logic reg_deep_uv_in,
   input wire logic reg_uv_in,
   input wire logic reg_ov_in,
   input wire logic trim_err_in,
   input wire logic coupling_test_active_in,
   input wire logic coupling_test_done,
   input wire logic coupling_test_aborted,
   input wire logic ch1_sync_slow,
   input wire logic ch1_sync_uv,
   input wire logic ch2_sync_slow,
   input wire logic ch2_sync_uv,
   input wire logic ch1_buffer_pending,
   input wire logic ch2_buffer_pending,
   input wire logic [4:0] payload_len,
   output logic setup_locked,
   output logic addr_multiplex_off,
   output logic ext_clk_1mhz,
   output logic ext_clk_4mhz,
   output logic sensor_id_global_enable,
   output logic check_bits_source,
   output logic regulator_high_level,
   output logic regulator_enable,
   output logic ch1_on,
   output logic ch2_on,
   output logic ch1_sync_pulse,
   output logic ch1_sync_long,
   output logic ch1_buffer_sets_length,
   output logic ch1_sync_method,
   output logic ch2_sync_pulse,
   output logic ch2_sync_long,
   output logic ch2_buffer_sets_length,
   output logic ch2_sync_method,
   output logic global_fault,
   output logic global_status
);
   localparam int PW = $clog2(PAR_CYCLES);
   localparam int NS = 7;   // Number of asynchronous inputs synchronised.

   // ****************************************************************
   // Storage.
   // ****************************************************************
   logic [15:0] gen_cfg;          // Setup-phase configuration.
   logic [15:0] ch_ctrl;          // Channel control.
   logic [15:0] status_lat;       // Latched status flags.
   logic [NS-1:0] sync_a;         // First synchroniser stage, read only by sync_b.
   logic [NS-1:0] sync_b;         // Second synchroniser stage.
   logic [PW-1:0] par_cnt;        // Parity recheck interval counter.
   logic parity_fault;            // Sticky result of the periodic check.
   logic ch1_tout;                // Channel one pin timeout pulse.
   logic ch2_tout;                // Channel two pin timeout pulse.

   // ****************************************************************
   // Synchronised pin and analog conditions.
   // ****************************************************************
   wire sync1_s = sync_b[0];
   wire sync2_s = sync_b[1];
   wire deep_uv_s = sync_b[2];
   wire uv_s = sync_b[3];
   wire ov_s = sync_b[4];
   wire trim_s = sync_b[5];
   wire ct_active_s = sync_b[6];

   // ****************************************************************
   // Address decode.
   // ****************************************************************
   wire hit_gen = (reg_addr == sctr_pkg::A_GEN_CFG);
   wire hit_ctl = (reg_addr == sctr_pkg::A_CH_CTRL);
   wire hit_nop = (reg_addr == sctr_pkg::A_NOP);
   wire hit_st1 = (reg_addr == sctr_pkg::A_STATUS1);
   wire hit_b1 = (reg_addr >= sctr_pkg::A_BUF1_LO) && (reg_addr <= sctr_pkg::A_BUF1_HI);
   wire hit_b2 = (reg_addr >= sctr_pkg::A_BUF2_LO) && (reg_addr <= sctr_pkg::A_BUF2_HI);
   wire hit_any = hit_gen | hit_ctl | hit_nop | hit_st1 | hit_b1 | hit_b2 | ext_addr_claim;
   wire access = reg_wr | reg_rd;
   // Setup register freezes after programming.
   wire gen_wr = reg_wr & hit_gen & ~setup_locked;   // RL2 RL23
   wire ctl_wr = reg_wr & hit_ctl;
   // The status register is read-clear; a write to it stores nothing.
   wire st1_rd = reg_rd & hit_st1;   // RL1

   // ****************************************************************
   // Regulator control.
   // ****************************************************************
   // A deep undervoltage forces the enable low even against a host write.
   wire reg_trip = deep_uv_s;   // RL18
   wire host_confirm = ctl_wr & ~reg_wdata[sctr_pkg::B_REG_EN];   // RL18
   wire [15:0] ctl_written = (reg_wdata & sctr_pkg::CH_CTRL_WMASK);
   wire [15:0] ctl_base = ctl_wr ? ctl_written : ch_ctrl;
   wire [15:0] reg_off_mask = 16'h0001 << sctr_pkg::B_REG_EN;
   wire [15:0] next_ch_ctrl = reg_trip ? (ctl_base & ~reg_off_mask) : ctl_base; // RL18

   // ****************************************************************
   // Status register events.
   // ****************************************************************
   wire buf1_flt = reg_wr & hit_b1 & ch1_buffer_pending;   // RL20
   wire buf2_flt = reg_wr & hit_b2 & ch2_buffer_pending;   // RL20
   wire link_flt = link_frame_err | (access & ~hit_any);   // RL21
   // Flag set vector, bit 15 first.
   wire [15:0] status_set = {coupling_test_done, coupling_test_aborted, 1'b0, // RL22
      link_flt, 1'b0, uv_s, 1'b0, deep_uv_s,                               // RL17
      ch2_tout, buf2_flt, ch2_sync_slow, ch2_sync_uv,
      ch1_tout, buf1_flt, ch1_sync_slow, ch1_sync_uv};
   // Live conditions merge at read time.
   wire [15:0] status_live = {2'b00, ct_active_s, 1'b0, trim_s, 1'b0, ov_s, 9'h000}; // RL22
   wire [15:0] uvl_mask = 16'h0001 << sctr_pkg::S_REG_DEEP_UV;
   // A read clears all latched flags but deep undervoltage.
   wire [15:0] clr_rd = st1_rd ? ~uvl_mask : 16'h0000;   // RL17
   wire [15:0] clr_cf = host_confirm ? uvl_mask : 16'h0000;   // RL18
   // Set wins over clear so an event in the clearing cycle survives.
   wire [15:0] next_status = ((status_lat & ~(clr_rd | clr_cf)) | status_set)
      & ~sctr_pkg::STATUS_LIVE_MASK;
   wire [15:0] status_view = status_lat | status_live;   // RL17

   // ****************************************************************
   // Read data selection.
   // ****************************************************************
   // The no-operation register stores nothing and reads as zero.
   wire [15:0] next_rdata = hit_gen ? gen_cfg :
                            hit_ctl ? ch_ctrl :
                            hit_st1 ? status_view : 16'h0000;   // RL16

   // ****************************************************************
   // Parity recheck.
   // ****************************************************************
   wire par_tick = (par_cnt == PW'(PAR_CYCLES - 1));
   wire par_bad = ~(^gen_cfg);   // Odd parity means the XOR of all bits is one.

   // ****************************************************************
   // Configuration outputs, decoded from register bits; sensor ID also gated by payload length.
   // ****************************************************************
   wire [1:0] clk_sel = gen_cfg[sctr_pkg::B_CLK_SEL +: 2];
   wire payload_fits = (payload_len == sctr_pkg::PAYLOAD_SHORT) ||
                       (payload_len == sctr_pkg::PAYLOAD_LONG);
   assign addr_multiplex_off = gen_cfg[sctr_pkg::B_AMUX_OFF];   // RL4
   assign ext_clk_1mhz = (clk_sel == sctr_pkg::CLK_EXT_1M);    // RL8
   assign ext_clk_4mhz = (clk_sel == sctr_pkg::CLK_EXT_4M);    // RL8
   assign sensor_id_global_enable = gen_cfg[sctr_pkg::B_SIDG] & payload_fits;   // RL9
   assign check_bits_source = gen_cfg[sctr_pkg::B_CHK_SRC];   // RL10
   assign regulator_high_level = gen_cfg[sctr_pkg::B_REG_LVL];
   assign regulator_enable = ch_ctrl[sctr_pkg::B_REG_EN];   // RL11
   assign ch1_on = ch_ctrl[sctr_pkg::B_CH1_ON];   // RL11
   assign ch2_on = ch_ctrl[sctr_pkg::B_CH2_ON];   // RL11
   assign global_fault = parity_fault;   // RL3
   // Summary returned with every frame.
   assign global_status = parity_fault | (|status_view);   // RL16

   // ****************************************************************
   // Synchroniser for pins and analog comparators.
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (ce) begin
         sync_a <= {coupling_test_active_in, trim_err_in, reg_ov_in, reg_uv_in,
                    reg_deep_uv_in, sync2_pin, sync1_pin};
         sync_b <= sync_a;
      end
   end

   // ****************************************************************
   // Configuration and control registers.
   // ****************************************************************
   // The lock has no way back short of a reset, by intent.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         gen_cfg <= sctr_pkg::GEN_CFG_RST;
         ch_ctrl <= sctr_pkg::CH_CTRL_RST;
         setup_locked <= 1'b0;
      end else if (ce) begin
         if (gen_wr) begin
            gen_cfg <= reg_wdata & sctr_pkg::GEN_CFG_WMASK;   // RL2
         end
         ch_ctrl <= next_ch_ctrl;   // RL11
         if (end_of_programming_cmd) begin
            setup_locked <= 1'b1;   // RL23
         end
      end
   end

   // ****************************************************************
   // Status latch and read data.
   // ****************************************************************
   // Read data and clearing share one edge.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_lat <= 16'h0000;
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         status_lat <= next_status;   // RL17
         if (reg_rd) begin
            reg_rdata <= next_rdata;   // RL1
         end
      end
   end

   // ****************************************************************
   // Periodic parity recheck.
   // ****************************************************************
   // Sticky until reset so a brief mismatch is kept.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         par_cnt <= '0;
         parity_fault <= 1'b0;
      end else if (ce) begin
         par_cnt <= par_tick ? '0 : par_cnt + 1'b1;   // RL3
         if (par_tick && par_bad) begin
            parity_fault <= 1'b1;   // RL3
         end
      end
   end

   // ****************************************************************
   // Per-channel sync logic.
   // ****************************************************************
   sctr_sync_chan #(.TOUT_CYCLES(TOUT_CYCLES)) u_ch1 (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ce(ce),
      .chan_on(ch1_on),
      .buf_sel(gen_cfg[sctr_pkg::B_CH1_BUF]),
      .method_sel(gen_cfg[sctr_pkg::B_CH1_METH]),
      .sync_allow(ch_ctrl[sctr_pkg::B_CH1_ALLOW]),
      .trig_src(gen_cfg[sctr_pkg::B_CH1_SRC +: 2]),
      .host_wr(ctl_wr),
      .host_code(reg_wdata[sctr_pkg::B_CH1_REQ +: 2]),
      .pin_level(sync1_s),
      .sync_pulse(ch1_sync_pulse),
      .sync_long(ch1_sync_long),
      .length_from_buffer(ch1_buffer_sets_length),
      .method_eff(ch1_sync_method),
      .tout_evt(ch1_tout)
   );

   sctr_sync_chan #(.TOUT_CYCLES(TOUT_CYCLES)) u_ch2 (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ce(ce),
      .chan_on(ch2_on),
      .buf_sel(gen_cfg[sctr_pkg::B_CH2_BUF]),
      .method_sel(gen_cfg[sctr_pkg::B_CH2_METH]),
      .sync_allow(ch_ctrl[sctr_pkg::B_CH2_ALLOW]),
      .trig_src(gen_cfg[sctr_pkg::B_CH2_SRC +: 2]),
      .host_wr(ctl_wr),
      .host_code(reg_wdata[sctr_pkg::B_CH2_REQ +: 2]),
      .pin_level(sync2_s),
      .sync_pulse(ch2_sync_pulse),
      .sync_long(ch2_sync_long),
      .length_from_buffer(ch2_buffer_sets_length),
      .method_eff(ch2_sync_method),
      .tout_evt(ch2_tout)
   );
endmodule : sctr_regs
`default_nettype wire

// ==== tb/sctr_regs_properties.sv ====
// Port assertions for the configuration and status bank.
`timescale 1ns/1ns
`default_nettype none
module sctr_regs_properties (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic ext_addr_claim,
   input wire logic end_of_programming_cmd,
   input wire logic setup_locked,
   input wire logic addr_multiplex_off,
   input wire logic ch1_on,
   input wire logic ch2_on,
   input wire logic ch1_sync_pulse,
   input wire logic ch1_sync_method,
   input wire logic ch1_buffer_sets_length
);
   // ****
   // Checks
   // ****
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // Writes taken per register.
   wire logic wr_cfg = ce && reg_wr && reg_addr == sctr_pkg::A_GEN_CFG;
   wire logic wr_ctl = ce && reg_wr && reg_addr == sctr_pkg::A_CH_CTRL;
   sequence s_locked;
      setup_locked [*4];
   endsequence
   property p_lock;
      ce && end_of_programming_cmd |=> s_locked;
   endproperty
   a_lock: assert property (p_lock) else $error("lock missing");
   property p_keep;
      wr_cfg && setup_locked |=> $stable(addr_multiplex_off) && setup_locked;
   endproperty
   a_keep: assert property (p_keep) else $error("locked write took");
   property p_amux;
      wr_cfg && !setup_locked |=> addr_multiplex_off == $past(reg_wdata[14]);
   endproperty
   a_amux: assert property (p_amux) else $error("mux bit wrong");
   property p_on;
      wr_ctl |=> ch1_on == $past(reg_wdata[0]) && ch2_on == $past(reg_wdata[5]);
   endproperty
   a_on: assert property (p_on) else $error("enable bit wrong");
   property p_once;
      ch1_sync_pulse |=> !ch1_sync_pulse;
   endproperty
   a_once: assert property (p_once) else $error("pulse repeated");
   property p_meth;
      ch1_sync_method |-> ch1_buffer_sets_length;
   endproperty
   a_meth: assert property (p_meth) else $error("method without buffer");
   property p_nop;
      ce && reg_wr && reg_addr == sctr_pkg::A_NOP |=> $stable({ch1_on, ch2_on, addr_multiplex_off});
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed state");
   property p_bad;
      ce && reg_rd && reg_addr == 6'h3F && !ext_addr_claim |=> reg_rdata == 16'h0000;
   endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not zero");
endmodule : sctr_regs_properties
bind sctr_regs sctr_regs_properties sctr_regs_properties_i (.*);
`default_nettype wire

// ==== tb/sctr_host_model.sv ====
// Behavioural host that issues register transfers to the bank.
`timescale 1ns/1ns
`default_nettype none
module sctr_host_model (
   input wire logic ref_clk,
   input wire logic [15:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [15:0] reg_wdata
);
   // Idle bus at time zero.
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
   end
   // Holds a request for one edge, then shows inverted fields.
   task automatic xfer(input logic rd, input logic [5:0] a, input logic [15:0] v,
                       output logic [15:0] q);
      @(posedge ref_clk);
      reg_wr <= !rd;
      reg_rd <= rd;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
      #1 q = reg_rdata;
   endtask : xfer
endmodule : sctr_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the configuration and status bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   // ****
   // Stimulus, model and design
   // ****
   logic ref_clk = 1'b0, resetn = 1'b0, eop = 1'b0, dv = 1'b0, long1 = 1'b0;
   logic [10:0] st = '0; // Status sources; 2:0 live.
   logic [1:0] pend = '0, pin = '0;
   logic [15:0] q, d, gcfg, cctl;
   logic reg_wr, reg_rd, amux, c1m, c4m, sid, chk, ven, on1, p1, l1, b1, m1, gf;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   int err_count = 0, n_checks = 0, cyc = 0, pulses = 0, n;
   initial forever #10 ref_clk = ~ref_clk;
   sctr_host_model sctr_host_model_i (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   sctr_regs #(.PAR_CYCLES(16), .TOUT_CYCLES(8)) sctr_regs_i (.ref_clk, .resetn, .ce(1'b1),
      .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .ext_addr_claim(1'b0),
      .end_of_programming_cmd(eop), .link_frame_err(st[8]), .sync1_pin(pin[0]), .sync2_pin(pin[1]),
      .reg_deep_uv_in(dv), .reg_uv_in(st[7]), .reg_ov_in(st[2]), .trim_err_in(st[1]),
      .coupling_test_active_in(st[0]), .coupling_test_done(st[10]), .coupling_test_aborted(st[9]),
      .ch1_sync_slow(st[4]), .ch1_sync_uv(st[3]), .ch2_sync_slow(st[6]), .ch2_sync_uv(st[5]),
      .ch1_buffer_pending(pend[0]), .ch2_buffer_pending(pend[1]), .payload_len(5'h0A),
      .setup_locked(), .addr_multiplex_off(amux), .ext_clk_1mhz(c1m), .ext_clk_4mhz(c4m),
      .sensor_id_global_enable(sid), .check_bits_source(chk), .regulator_high_level(),
      .regulator_enable(ven), .ch1_on(on1), .ch2_on(), .ch1_sync_pulse(p1), .ch1_sync_long(l1),
      .ch1_buffer_sets_length(b1), .ch1_sync_method(m1), .ch2_sync_pulse(), .ch2_sync_long(),
      .ch2_buffer_sets_length(), .ch2_sync_method(), .global_fault(gf), .global_status());
   task automatic w(input logic [5:0] a, input logic [15:0] v);
      sctr_host_model_i.xfer(1'b0, a, v, q);
   endtask : w
   task automatic r(input logic [5:0] a);
      sctr_host_model_i.xfer(1'b1, a, 16'h0000, q);
   endtask : r
   // Bit 15 gives the word odd weight.
   function automatic logic [15:0] par(input logic [15:0] v);
      return {~^v[14:0], v[14:0]};
   endfunction : par
   task automatic report_and_stop();
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // Count pulses off the falling edge.
   always @(negedge ref_clk) begin
      if (p1 === 1'b1) begin
         pulses++;
         long1 = l1;
      end
   end
   // A hang counts as a mismatch.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      n = $urandom(32'h57df);
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      r(sctr_pkg::A_GEN_CFG);
      `CHK("gen_cfg", 16'h8000, q)
      r(sctr_pkg::A_CH_CTRL);
      `CHK("ch_ctrl", 16'h0442, q)
      cctl = 16'h0443;
      w(sctr_pkg::A_CH_CTRL, cctl);
      @(posedge ref_clk) pin[0] <= 1'b1;
      repeat (20) @(posedge ref_clk);
      pin[0] <= 1'b0;
      r(sctr_pkg::A_STATUS1);
      `CHK("timeout", 16'h0008, q)
      for (int k = 0; k < 4; k++) begin
         d = par((16'($urandom()) & 16'h7FC7) | (16'(k) << 3));
         w(sctr_pkg::A_GEN_CFG, d);
         r(sctr_pkg::A_GEN_CFG);
         `CHK("cfg", d, q)
         `CHK("clk1", k == 1, c1m)
         `CHK("clk4", k == 2, c4m)
         `CHK("amux", d[14], amux)
         `CHK("sid", d[2], sid)
         `CHK("chk", d[1], chk)
         `CHK("buf", d[9] | (d[8:7] == 2'h2), b1)
      end
      w(sctr_pkg::A_GEN_CFG, par(16'h0080));
      for (int i = 0; i < 16; i++) begin
         d = 16'h0400 | (16'($urandom()) & 16'h037B);
         n = pulses;
         w(sctr_pkg::A_CH_CTRL, d);
         repeat (3) @(posedge ref_clk);
         `CHK("pulses", 32'(cctl[0] & cctl[1] & ^d[4:3]), pulses - n)
         if (pulses > n) `CHK("long", d[4], long1)
         cctl = d;
      end
      r(6'h3F);
      `CHK("bad_addr", 16'h0000, q)
      @(posedge ref_clk) st <= '1;
      pend[0] <= 1'b1;
      w(sctr_pkg::A_BUF1_LO, 16'h1234);
      @(posedge ref_clk) st[10:3] <= '0;
      pend[0] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      r(sctr_pkg::A_STATUS1);
      `CHK("status", 16'hFE37, q)
      r(sctr_pkg::A_STATUS1);
      `CHK("live", 16'h2A00, q)
      @(posedge ref_clk) st <= '0;
      dv <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 `CHK("ven", 1'b0, ven)
      @(posedge ref_clk) dv <= 1'b0;
      repeat (4) @(posedge ref_clk);
      r(sctr_pkg::A_STATUS1);
      `CHK("uv_flag", 16'h0100, q)
      cctl = cctl & 16'hFBFF;
      w(sctr_pkg::A_CH_CTRL, cctl);
      r(sctr_pkg::A_STATUS1);
      `CHK("uv_clear", 16'h0000, q)
      w(sctr_pkg::A_NOP, 16'($urandom()));
      r(sctr_pkg::A_CH_CTRL);
      `CHK("nop", cctl & sctr_pkg::CH_CTRL_WMASK, q)
      `CHK("gfault", 1'b0, gf)
      gcfg = par(16'h0080) ^ 16'h8000;
      w(sctr_pkg::A_GEN_CFG, gcfg);
      repeat (40) @(posedge ref_clk);
      `CHK("gfault", 1'b1, gf)
      @(posedge ref_clk) eop <= 1'b1;
      @(posedge ref_clk) eop <= 1'b0;
      w(sctr_pkg::A_GEN_CFG, par(16'h4000));
      r(sctr_pkg::A_GEN_CFG);
      `CHK("locked", gcfg, q)
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
